// >>> rtl/ppuc_regs.vh
`ifndef PPUC_REGS_VH
`define PPUC_REGS_VH
// ----------------------------------------------------------------------------
// register word indexes (12-bit) and byte addresses (14-bit, _B)
// ----------------------------------------------------------------------------
`define PPUC_ADDR_PULLUP_0_3    12'h3f0
`define PPUC_ADDR_PULLUP_10_13  12'h3f3
`define PPUC_IDX_PULLUP_10_13   12'h3f3
`define PPUC_IDX_PULLUP_0_3     12'h3f0
`define PPUC_IDX_OUT_MODE       12'h3f7
`define PPUC_ADDR_PULLUP_0_3_B  14'h0fc0
`define PPUC_ADDR_PULLUP_10_13_B 14'h0fcc
`define PPUC_ADDR_OUT_MODE_B    14'h0fdc
`define PPUC_ADDR_BUS_MODE_B    14'h0fe0
`define PPUC_ADDR_STATUS_B      14'h0fe4
// ----------------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------------
`define PPUC_RST_PULLUP         8'h00
`define PPUC_RST_OUT_MODE       8'h00
`define PPUC_RST_BUS_MODE       8'h00
`define PPUC_OUT_MODE_P1OD_BIT  0
`define PPUC_BUS_EXP_BIT        0
`define PPUC_BUS_WIDE_BIT       1
`define PPUC_BUS_P1DATA_BIT     2
`define PPUC_RESP_OKAY          2'b00
`define PPUC_RESP_SLVERR        2'b10
`endif

// >>> rtl/ppuc_group_pu.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// per-pin pull-up gating for one group of pins
// ----------------------------------------------------------------------------
module ppuc_group_pu #(
    parameter N = 4
) (
    input  wire         grp_en,
    input  wire [N-1:0] dir_out,
    input  wire [N-1:0] bus_use,
    output wire [N-1:0] pu_en
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            // pull-up only with its bit set, pin input, pin not a bus line
            assign pu_en[i] = grp_en & ~dir_out[i] & ~bus_use[i];
        end
    endgenerate
endmodule // ppuc_group_pu

// >>> rtl/ppuc_ctrl.v
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "ppuc_regs.vh"
module ppuc_ctrl (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [13:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [13:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [31:0] dir_p0_p3,
    input  wire [31:0] dir_p10_p13,
    input  wire [31:0] bus_pin_p0_p3,
    input  wire [31:0] bus_pin_p10_p13,
    output wire [31:0] pad_pu_p0_p3,
    output wire [31:0] pad_pu_p10_p13,
    output wire        port1_pch_off
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [7:0]  pullup_ctrl_ports_0_to_3_r;
    reg  [7:0]  pullup_ctrl_ports_10_to_13_r;
    reg  [7:0]  port_output_mode_reg_r;
    reg  [7:0]  bus_mode_r;
    reg  [13:0] awaddr_r;
    reg         aw_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_held_r;
    wire        wr_go;
    wire [13:0] wa;
    wire [31:0] wd;
    wire [3:0]  ws;
    reg  [31:0] rd_nxt;
    reg         rd_hit;
    wire [2:0]  wr_sel;
    wire [2:0]  rd_sel;

    // ------------------------------------------------------------------------
    // address decode, shared by the write and read paths
    // ------------------------------------------------------------------------
    // register select codes
    localparam [2:0] SEL_NONE   = 3'h0;
    localparam [2:0] SEL_PU_LO  = 3'h1;
    localparam [2:0] SEL_PU_HI  = 3'h2;
    localparam [2:0] SEL_MODE   = 3'h3;
    localparam [2:0] SEL_BUS    = 3'h4;
    localparam [2:0] SEL_STATUS = 3'h5;

    function [2:0] reg_sel;
        input [13:0] a;
        begin
            case (a)
                `PPUC_ADDR_PULLUP_0_3_B:   reg_sel = SEL_PU_LO;
                `PPUC_ADDR_PULLUP_10_13_B: reg_sel = SEL_PU_HI;
                `PPUC_ADDR_OUT_MODE_B:     reg_sel = SEL_MODE;
                `PPUC_ADDR_BUS_MODE_B:     reg_sel = SEL_BUS;
                `PPUC_ADDR_STATUS_B:       reg_sel = SEL_STATUS;
                default:                   reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    assign wr_sel = reg_sel(wa);
    assign rd_sel = reg_sel(s_axi_araddr);

    // ------------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------------
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign wa = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wd = w_held_r ? wdata_r : s_axi_wdata;
    assign ws = w_held_r ? wstrb_r : s_axi_wstrb;
    // write fires once both halves are present, in either order
    assign wr_go = (aw_held_r | (s_axi_awvalid & s_axi_awready)) &
                   (w_held_r | (s_axi_wvalid & s_axi_wready));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 14'h0000;
            wdata_r      <= 32'h00000000;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PPUC_RESP_OKAY;
            pullup_ctrl_ports_0_to_3_r   <= `PPUC_RST_PULLUP;
            pullup_ctrl_ports_10_to_13_r <= `PPUC_RST_PULLUP;
            port_output_mode_reg_r       <= `PPUC_RST_OUT_MODE;
            bus_mode_r                   <= `PPUC_RST_BUS_MODE;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel != SEL_NONE) ? `PPUC_RESP_OKAY : `PPUC_RESP_SLVERR;
                // status is read-only: a write to it is answered OKAY and dropped
                if (ws[0]) begin
                    case (wr_sel)
                        SEL_PU_LO: pullup_ctrl_ports_0_to_3_r   <= wd[7:0];
                        SEL_PU_HI: pullup_ctrl_ports_10_to_13_r <= wd[7:0];
                        SEL_MODE:  port_output_mode_reg_r       <= wd[7:0];
                        SEL_BUS:   bus_mode_r                   <= wd[7:0];
                        default: ;
                    endcase
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_r <= 1'b1;
                    awaddr_r  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_r <= 1'b1;
                    wdata_r  <= s_axi_wdata;
                    wstrb_r  <= s_axi_wstrb;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // pad pull-up gating, eight groups per register
    // ------------------------------------------------------------------------
    wire [31:0] live_pu_lo;
    wire [31:0] live_pu_hi;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_grp
            // ports 0-3 groups follow their register bit one to one
            ppuc_group_pu #(.N(4)) u_lo (
                .grp_en  (pullup_ctrl_ports_0_to_3_r[g]),
                .dir_out (dir_p0_p3[4*g+3:4*g]),
                .bus_use (bus_pin_p0_p3[4*g+3:4*g]),
                .pu_en   (live_pu_lo[4*g+3:4*g])
            );
            // bit 3 covers only pin 4 of port 11; pins 5-7 have no pull-up
            ppuc_group_pu #(.N(4)) u_hi (
                .grp_en  (pullup_ctrl_ports_10_to_13_r[g]),
                .dir_out ((g == 3) ? (dir_p10_p13[15:12] | 4'he) : dir_p10_p13[4*g+3:4*g]),
                .bus_use (bus_pin_p10_p13[4*g+3:4*g]),
                .pu_en   (live_pu_hi[4*g+3:4*g])
            );
        end
    endgenerate
    assign pad_pu_p0_p3   = live_pu_lo;
    assign pad_pu_p10_p13 = live_pu_hi;

    // ------------------------------------------------------------------------
    // port 1 output mode
    // ------------------------------------------------------------------------
    // P driver off for pseudo open-drain; follows the bit regardless of bus mode
    assign port1_pch_off = port_output_mode_reg_r[`PPUC_OUT_MODE_P1OD_BIT];

    // ------------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always @* begin
        rd_nxt = 32'h00000000;
        rd_hit = 1'b1;
        // an unmapped word reads zero and answers SLVERR
        case (rd_sel)
            SEL_PU_LO:  rd_nxt = {24'h000000, pullup_ctrl_ports_0_to_3_r};
            SEL_PU_HI:  rd_nxt = {24'h000000, pullup_ctrl_ports_10_to_13_r};
            SEL_MODE:   rd_nxt = {24'h000000, port_output_mode_reg_r};
            SEL_BUS:    rd_nxt = {24'h000000, bus_mode_r};
            SEL_STATUS: rd_nxt = {31'h00000000, port1_pch_off};
            default:    rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PPUC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_nxt;
            s_axi_rresp  <= rd_hit ? `PPUC_RESP_OKAY : `PPUC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ppuc_ctrl

// >>> dv/ppuc_ctrl_properties.sv
`timescale 1ns/1ps
module ppuc_ctrl_properties (
    input wire        clk,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [31:0] dir_p0_p3,
    input wire [31:0] dir_p10_p13,
    input wire [31:0] bus_pin_p0_p3,
    input wire [31:0] bus_pin_p10_p13,
    input wire [31:0] pad_pu_p0_p3,
    input wire [31:0] pad_pu_p10_p13,
    input wire        port1_pch_off
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    chk_pu_input_only: assert property ((pad_pu_p0_p3 & (dir_p0_p3 | bus_pin_p0_p3)) == 0)
        else $error("pull-up on output or bus pin, ports 0-3");
    chk_pu_bus_free: assert property ((pad_pu_p10_p13 & (dir_p10_p13 | bus_pin_p10_p13)) == 0)
        else $error("pull-up on output or bus pin, ports 10-13");
    chk_p11_upper_off: assert property (pad_pu_p10_p13[15:13] == 3'h0)
        else $error("port 11 pins 5-7 pulled up");
    chk_write_answer: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read response late");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_mode_cause: assert property ($changed(port1_pch_off) |-> $rose(s_axi_bvalid))
        else $error("output mode changed without write");
endmodule // ppuc_ctrl_properties
bind ppuc_ctrl ppuc_ctrl_properties i_ppuc_ctrl_properties (.clk, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .dir_p0_p3, .dir_p10_p13, .bus_pin_p0_p3, .bus_pin_p10_p13,
    .pad_pu_p0_p3, .pad_pu_p10_p13, .port1_pch_off);

// >>> dv/ppuc_ctrl_bench.sv
`timescale 1ns/1ps
`include "ppuc_regs.vh"
module ppuc_ctrl_bench;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic [31:0] s_axi_wdata = 0, dir_p0_p3 = 0, dir_p10_p13 = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] bus_pin_p0_p3 = 0, bus_pin_p10_p13 = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         port1_pch_off;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, pad_pu_p0_p3, pad_pu_p10_p13;
    int          failures = 0;
    int          tests_run = 0;
    ppuc_ctrl i_ppuc_ctrl (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .dir_p0_p3,
        .dir_p10_p13, .bus_pin_p0_p3, .bus_pin_p10_p13, .pad_pu_p0_p3, .pad_pu_p10_p13,
        .port1_pch_off);
    always #12.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // bus cycles: bready and rready stay high throughout
    // ------------------------------------------------------------------------
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // large package: no small-package configuration bytes to fill
    task automatic t_reset;
        rd(`PPUC_ADDR_PULLUP_0_3_B, 32'h0, `PPUC_RESP_OKAY);
        rd(`PPUC_ADDR_PULLUP_10_13_B, 32'h0, `PPUC_RESP_OKAY);
        rd(`PPUC_ADDR_OUT_MODE_B, 32'h0, `PPUC_RESP_OKAY);
        check(pad_pu_p10_p13 | pad_pu_p0_p3, 32'h0);
    endtask
    // single-chip mode on the large package, so bits 2-7 may be set
    task automatic t_pu10;
        for (int i = 0; i < 8; i++) begin
            wr(`PPUC_ADDR_PULLUP_10_13_B, 32'h1 << i, `PPUC_RESP_OKAY);
            @(negedge clk);
            check(pad_pu_p10_p13, (i == 3) ? 32'h1000 : 32'hf << (4 * i));
            @(posedge clk);
        end
        wr(`PPUC_ADDR_PULLUP_10_13_B, 32'hff, `PPUC_RESP_OKAY);
        dir_p10_p13 <= 32'h0f0f0f0f;
        bus_pin_p10_p13 <= 32'h00ff0000;
        @(negedge clk);
        check(pad_pu_p10_p13, 32'hf00010f0);
        @(posedge clk);
        rd(`PPUC_ADDR_PULLUP_10_13_B, 32'hff, `PPUC_RESP_OKAY);
        wr(`PPUC_ADDR_PULLUP_10_13_B, 32'h0, `PPUC_RESP_OKAY);
        @(negedge clk);
        check(pad_pu_p10_p13, 32'h0);
        @(posedge clk);
    endtask
    task automatic t_pu0;
        wr(`PPUC_ADDR_BUS_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        rd(`PPUC_ADDR_BUS_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        // back to single-chip mode before the ports 0-3 register is set
        wr(`PPUC_ADDR_BUS_MODE_B, 32'h0, `PPUC_RESP_OKAY);
        wr(`PPUC_ADDR_PULLUP_0_3_B, 32'hcf, `PPUC_RESP_OKAY);
        bus_pin_p0_p3 <= 32'h0000ff00;
        @(negedge clk);
        check(pad_pu_p0_p3, 32'hff0000ff);
        @(posedge clk);
        dir_p0_p3 <= 32'h10000001;
        @(negedge clk);
        check(pad_pu_p0_p3, 32'hef0000fe);
        @(posedge clk);
        bus_pin_p0_p3 <= 32'h00000000;
        @(negedge clk);
        check(pad_pu_p0_p3, 32'hef00fffe);
        @(posedge clk);
    endtask
    // single-chip mode on the large package: the output-mode bit may be set
    task automatic t_mode;
        wr(`PPUC_ADDR_OUT_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        @(negedge clk);
        check(port1_pch_off, 1'b1);
        @(posedge clk);
        rd(`PPUC_ADDR_STATUS_B, 32'h1, `PPUC_RESP_OKAY);
        rd(`PPUC_ADDR_OUT_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        wr(`PPUC_ADDR_OUT_MODE_B, 32'h0, `PPUC_RESP_OKAY);
        @(negedge clk);
        check(port1_pch_off, 1'b0);
        @(posedge clk);
        s_axi_wstrb <= 4'he;
        wr(`PPUC_ADDR_OUT_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(`PPUC_ADDR_OUT_MODE_B, 32'h0, `PPUC_RESP_OKAY);
        check(port1_pch_off, 1'b0);
        wr(14'h0100, 32'hff, `PPUC_RESP_SLVERR);
        rd(14'h0100, 32'h0, `PPUC_RESP_SLVERR);
    endtask
    task automatic t_reset_again;
        wr(`PPUC_ADDR_PULLUP_10_13_B, 32'hff, `PPUC_RESP_OKAY);
        wr(`PPUC_ADDR_OUT_MODE_B, 32'h1, `PPUC_RESP_OKAY);
        @(negedge clk);
        check(pad_pu_p10_p13, 32'hf00010f0);
        check(port1_pch_off, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check(pad_pu_p10_p13, 32'h0);
        check(port1_pch_off, 1'b0);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`PPUC_ADDR_PULLUP_10_13_B, 32'h0, `PPUC_RESP_OKAY);
        rd(`PPUC_ADDR_OUT_MODE_B, 32'h0, `PPUC_RESP_OKAY);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_pu10;
        t_pu0;
        t_mode;
        t_reset_again;
        complete_run;
    end
    initial begin
        #100us;
        failures++;
        complete_run;
    end
endmodule // ppuc_ctrl_bench
